// File: verilog/vfic_consts.svh
// Offsets, field positions, reset values and masks of the fast interrupt controller
`ifndef VFIC_CONSTS_SVH
`define VFIC_CONSTS_SVH

// Device register map (byte addresses)
`define VFIC_OFF_NORM_STAT   32'hFFFF0000
`define VFIC_OFF_NORM_RAW    32'hFFFF0004
`define VFIC_OFF_NORM_EN     32'hFFFF0008
`define VFIC_OFF_NORM_CLR    32'hFFFF000C
`define VFIC_OFF_SOFT_CFG    32'hFFFF0010
`define VFIC_OFF_VEC_BASE    32'hFFFF0014
`define VFIC_OFF_VEC_PTR     32'hFFFF001C
`define VFIC_OFF_PRIO0       32'hFFFF0020
`define VFIC_OFF_NEST_CTRL   32'hFFFF0030
`define VFIC_OFF_FAST_STAT   32'hFFFF0100
`define VFIC_OFF_FAST_RAW    32'hFFFF0104
`define VFIC_OFF_FAST_EN     32'hFFFF0108
`define VFIC_OFF_FAST_CLR    32'hFFFF010C

// Field layout
`define VFIC_NUM_SRC         22
`define VFIC_NUM_PERIPH      20
`define VFIC_SOFT_NORM_BIT   1
`define VFIC_SOFT_FAST_BIT   2
`define VFIC_SOFT_CFG_MASK   32'h00000006
`define VFIC_PRIO0_MASK      32'h77777770
`define VFIC_NEST_NORM_BIT   0
`define VFIC_NEST_FAST_BIT   1
`define VFIC_PRIO_FIRST      1
`define VFIC_PRIO_LAST       7
`define VFIC_PRIO_UNASSIGNED 3'h7
`define VFIC_PRIO_OR_SRC     3'h0
`define VFIC_RESET_WORD      32'h00000000

// Controller register map (AXI4-Lite byte addresses)
`define VFIC_CTL_ADDR        4'h0
`define VFIC_CTL_WDATA       4'h4
`define VFIC_CTL_GO          4'h8
`define VFIC_CTL_STATUS      4'hC
`define VFIC_CTL_RDATA       5'h10
`define VFIC_GO_START_BIT    0
`define VFIC_GO_WRITE_BIT    1
`define VFIC_AXI_OKAY        2'h0
`define VFIC_AXI_SLVERR      2'h2

`endif

// File: verilog/vfic_pkg.sv
// Types shared by both ends of the fast interrupt controller
package vfic_pkg;
	typedef logic [2:0] vfic_prio_t;
	typedef logic [4:0] vfic_src_idx_t;
	// Link command state of the controller end
	typedef enum logic [0:0] {
		VFIC_IDLE = 1'b0,
		VFIC_WAIT = 1'b1
	} vfic_cmd_state_t;
endpackage

// File: verilog/vfic_link_if.sv
// Register link and request lines between controller end and device end
interface vfic_link_if;
	logic        req;
	logic        we;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        ack;
	logic        irq;
	logic        fiq;

	modport dev (
		input  req,
		input  we,
		input  addr,
		input  wdata,
		output rdata,
		output ack,
		output irq,
		output fiq
	);

	modport ctl (
		output req,
		output we,
		output addr,
		output wdata,
		input  rdata,
		input  ack,
		input  irq,
		input  fiq
	);
endinterface

// File: verilog/vfic_prio_pick.sv
// Picks the highest-priority active source, lowest number on a tie
`include "vfic_consts.svh"
module vfic_prio_pick (
	input  wire logic [`VFIC_NUM_SRC-1:0]   active,
	input  wire logic [3*`VFIC_NUM_SRC-1:0] prio_flat,
	output vfic_pkg::vfic_src_idx_t         win_idx,
	output logic                            win_valid
);
	vfic_pkg::vfic_prio_t best;

	// Ascending scan with strict compare keeps the lowest number on ties
	always_comb begin
		best = 3'h7;
		win_idx = 5'h00;
		win_valid = 1'b0;
		for (int k = 0; k < `VFIC_NUM_SRC; k++) begin
			if (active[k] && (!win_valid || prio_flat[3*k +: 3] < best)) begin // [RL24]
				best = prio_flat[3*k +: 3];
				win_idx = 5'(k);
				win_valid = 1'b1;
			end
		end
	end
endmodule // vfic_prio_pick

// File: verilog/vfic_device.sv
// Device end: fast masks, status, programmed interrupts, vector and priority logic
//
// Rules of the document for this block
// [RL1] Fast request only while fast enable bit set
// [RL2] Fast enable writes only set bits
// [RL3] Write-only clear register drops ones written
// [RL4] Software clears enable only inside its handler
// [RL5] Software never clears a possibly pending source
// [RL6] Fast status is raw AND fast mask
// [RL7] Each fast status bit drives fast request
// [RL8] Soft config bit 2 drives fast bit 1
// [RL9] Soft config bit 1 drives normal bit 1
// [RL10] Programmed interrupts bypass both enable masks
// [RL11] Sources hold requests beyond minimum latency
// [RL12] Nesting control bits enable vectored handling
// [RL13] Eight levels each, fast outranks normal
// [RL14] Both vectored gives sixteen nesting levels; nest_q bit 1 is stored but drives nothing
// [RL15] Three-bit priority fields, values 0 to 7
// [RL16] Vector base 16 bits, upper half zero
// [RL17] Vector pointer holds base and winner
// [RL18] Software reads pointer only when vectored
// [RL19] Priority group zero field positions fixed
// [RL20] Source zero has no priority field
// [RL21] Fast enable set clears normal enable
// [RL22] Fixed map of twenty-two sources
// [RL23] OR of fast bits 31..1 feeds bit 0
// [RL24] Priority ties go to lowest source number
`include "vfic_consts.svh"
module vfic_device (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic                        ce,
	input  wire logic [`VFIC_NUM_PERIPH-1:0] periph_src,
	vfic_link_if.dev                         link
);
	logic [31:0]                        fast_en_q;
	logic [31:0]                        norm_en_q;
	logic [31:0]                        soft_cfg_q;
	logic [15:0]                        vec_base_q;
	logic [31:0]                        prio0_q;
	logic [1:0]                         nest_q;
	logic [`VFIC_NUM_PERIPH-1:0]        periph_q;
	logic [31:0]                        rdata_q;
	logic                               ack_q;
	logic                               irq_q;
	logic                               fiq_q;
	logic [29:0]                        periph_word;
	logic [29:0]                        fast_upper;
	logic [29:0]                        norm_upper;
	logic                               fast_or;
	logic                               soft_norm;
	logic                               soft_fast;
	logic [31:0]                        fast_raw;
	logic [31:0]                        fast_stat;
	logic [31:0]                        norm_raw;
	logic [31:0]                        norm_stat;
	logic [31:0]                        vec_ptr;
	logic [31:0]                        rd_d;
	logic [3*`VFIC_NUM_SRC-1:0]         prio_flat;
	vfic_pkg::vfic_src_idx_t            win_idx;
	logic                               win_valid;
	logic                               wr;
	logic                               rd;

	////////////////////////////////////////////////////////////////////////////////
	// Link decode
	assign wr = ce && link.req && link.we;
	assign rd = ce && link.req && !link.we;

	////////////////////////////////////////////////////////////////////////////////
	// Raw and status words
	// Peripherals sit on bits 21..2, bits above are unused sources
	assign periph_word = {10'h000, periph_q}; // [RL22]
	assign soft_norm   = soft_cfg_q[`VFIC_SOFT_NORM_BIT];
	assign soft_fast   = soft_cfg_q[`VFIC_SOFT_FAST_BIT];
	assign fast_upper  = periph_word & fast_en_q[31:2]; // [RL1] [RL6]
	assign norm_upper  = periph_word & norm_en_q[31:2];
	// Bit 1 is the unmaskable programmed source; OR covers bits 31..1 only
	assign fast_or     = (|fast_upper) | soft_fast; // [RL23] [RL10]
	assign fast_raw    = {periph_word, soft_fast, fast_or}; // [RL8] [RL23]
	assign fast_stat   = {fast_upper, soft_fast, fast_or & fast_en_q[0]}; // [RL6] [RL8] [RL10]
	assign norm_raw    = {periph_word, soft_norm, fast_or}; // [RL9] [RL23]
	assign norm_stat   = {norm_upper, soft_norm, fast_or & norm_en_q[0]}; // [RL9] [RL10]

	////////////////////////////////////////////////////////////////////////////////
	// Priority of every source
	// Sources 8..21 without a field in group zero rank lowest; source 0 ranks highest
	always_comb begin
		prio_flat = '0;
		prio_flat[2:0] = `VFIC_PRIO_OR_SRC; // [RL20]
		for (int k = 1; k < `VFIC_NUM_SRC; k++) begin
			prio_flat[3*k +: 3] = `VFIC_PRIO_UNASSIGNED;
		end
		for (int k = `VFIC_PRIO_FIRST; k <= `VFIC_PRIO_LAST; k++) begin
			prio_flat[3*k +: 3] = prio0_q[4*k +: 3]; // [RL15] [RL19]
		end
	end

	// Winner among active normal sources
	vfic_prio_pick u_pick (
		.active    (norm_stat[`VFIC_NUM_SRC-1:0]),
		.prio_flat (prio_flat),
		.win_idx   (win_idx),
		.win_valid (win_valid)
	);

	// Pointer into the table of 32 handler addresses
	assign vec_ptr = {9'h000, vec_base_q, win_valid ? win_idx : 5'h00, 2'b00}; // [RL17]

	////////////////////////////////////////////////////////////////////////////////
	// Fast enable mask: set-only writes, clear register, cross-clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_en_q <= `VFIC_RESET_WORD;
		end else if (wr && link.addr == `VFIC_OFF_FAST_EN) begin
			fast_en_q <= fast_en_q | link.wdata; // [RL2]
		end else if (wr && link.addr == `VFIC_OFF_FAST_CLR) begin
			fast_en_q <= fast_en_q & ~link.wdata; // [RL3]
		end else if (wr && link.addr == `VFIC_OFF_NORM_EN) begin
			fast_en_q <= fast_en_q & ~link.wdata; // [RL21]
		end
	end

	// Normal enable mask, mirror of the fast one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			norm_en_q <= `VFIC_RESET_WORD;
		end else if (wr && link.addr == `VFIC_OFF_NORM_EN) begin
			norm_en_q <= norm_en_q | link.wdata;
		end else if (wr && link.addr == `VFIC_OFF_NORM_CLR) begin
			norm_en_q <= norm_en_q & ~link.wdata;
		end else if (wr && link.addr == `VFIC_OFF_FAST_EN) begin
			norm_en_q <= norm_en_q & ~link.wdata; // [RL21]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_cfg_q <= `VFIC_RESET_WORD;
			vec_base_q <= 16'h0000;
			prio0_q    <= `VFIC_RESET_WORD;
			nest_q     <= 2'b00;
		end else if (wr) begin
			if (link.addr == `VFIC_OFF_SOFT_CFG) begin
				soft_cfg_q <= link.wdata & `VFIC_SOFT_CFG_MASK; // [RL8] [RL9]
			end
			if (link.addr == `VFIC_OFF_VEC_BASE) begin
				vec_base_q <= link.wdata[15:0]; // [RL16]
			end
			if (link.addr == `VFIC_OFF_PRIO0) begin
				prio0_q <= link.wdata & `VFIC_PRIO0_MASK; // [RL20]
			end
			if (link.addr == `VFIC_OFF_NEST_CTRL) begin
				nest_q <= link.wdata[1:0]; // [RL12]
			end
		end
	end

	// Peripheral levels sampled each enabled cycle; a pulse that misses every enabled rising edge is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_q <= '0;
		end else if (ce) begin
			periph_q <= periph_src; // [RL11]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read multiplexer; unmapped and write-only offsets read zero
	always_comb begin
		unique case (link.addr)
			`VFIC_OFF_NORM_STAT: rd_d = norm_stat;
			`VFIC_OFF_NORM_RAW:  rd_d = norm_raw;
			`VFIC_OFF_NORM_EN:   rd_d = norm_en_q;
			`VFIC_OFF_SOFT_CFG:  rd_d = soft_cfg_q;
			`VFIC_OFF_VEC_BASE:  rd_d = {16'h0000, vec_base_q}; // [RL16]
			`VFIC_OFF_VEC_PTR:   rd_d = vec_ptr; // [RL17] [RL18]
			`VFIC_OFF_PRIO0:     rd_d = prio0_q;
			`VFIC_OFF_NEST_CTRL: rd_d = {30'h00000000, nest_q};
			`VFIC_OFF_FAST_STAT: rd_d = fast_stat; // [RL6]
			`VFIC_OFF_FAST_RAW:  rd_d = fast_raw;
			`VFIC_OFF_FAST_EN:   rd_d = fast_en_q;
			default:             rd_d = `VFIC_RESET_WORD; // [RL3]
		endcase
	end

	// Answer one cycle after each request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_q   <= 1'b0;
			rdata_q <= `VFIC_RESET_WORD;
		end else if (ce) begin
			ack_q <= link.req;
			if (rd) begin
				rdata_q <= rd_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request lines to the core
	// Vectored normal requests step aside while a fast one is up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
			fiq_q <= 1'b0;
		end else if (ce) begin
			fiq_q <= fast_or; // [RL7] [RL23]
			irq_q <= (|norm_stat) && !(nest_q[`VFIC_NEST_NORM_BIT] && fast_or); // [RL13] [RL14]
		end
	end

	assign link.ack   = ack_q;
	assign link.rdata = rdata_q;
	assign link.irq   = irq_q;
	assign link.fiq   = fiq_q;
endmodule // vfic_device

// File: verilog/vfic_ctl.sv
// Controller end: AXI4-Lite command registers driving the device link
`include "vfic_consts.svh"
module vfic_ctl (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	vfic_link_if.ctl         link
);
	logic [4:0]                aw_q;
	logic [31:0]               w_q;
	logic                      have_aw_q;
	logic                      have_w_q;
	logic                      bvalid_q;
	logic [1:0]                bresp_q;
	logic                      rvalid_q;
	logic [31:0]               rdata_q;
	logic [1:0]                rresp_q;
	logic [31:0]               cmd_addr_q;
	logic [31:0]               cmd_wdata_q;
	logic [31:0]               link_rdata_q;
	logic                      req_q;
	logic                      we_q;
	vfic_pkg::vfic_cmd_state_t st_q;
	logic                      do_wr;
	logic                      go;

	////////////////////////////////////////////////////////////////////////////////
	// Write channels: address and data taken in either order
	assign do_wr = have_aw_q && have_w_q && !bvalid_q;
	assign go = do_wr && aw_q == {1'b0, `VFIC_CTL_GO} && w_q[`VFIC_GO_START_BIT]
		&& st_q == vfic_pkg::VFIC_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_aw_q <= 1'b0;
			have_w_q  <= 1'b0;
			aw_q      <= 5'h00;
			w_q       <= 32'h00000000;
			bvalid_q  <= 1'b0;
			bresp_q   <= `VFIC_AXI_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w_q <= 1'b1;
				w_q      <= s_axi_wdata;
			end
			if (do_wr) begin
				have_aw_q <= 1'b0;
				have_w_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (aw_q > `VFIC_CTL_RDATA) ? `VFIC_AXI_SLVERR : `VFIC_AXI_OKAY;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Byte strobes ignored: command words are always whole
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_addr_q  <= 32'h00000000;
			cmd_wdata_q <= 32'h00000000;
		end else if (ce && do_wr) begin
			if (aw_q == {1'b0, `VFIC_CTL_ADDR}) begin
				cmd_addr_q <= w_q;
			end
			if (aw_q == {1'b0, `VFIC_CTL_WDATA}) begin
				cmd_wdata_q <= w_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link command: one request pulse, wait for the device answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q         <= vfic_pkg::VFIC_IDLE;
			req_q        <= 1'b0;
			we_q         <= 1'b0;
			link_rdata_q <= 32'h00000000;
		end else if (ce) begin
			req_q <= go;
			unique case (st_q)
				vfic_pkg::VFIC_IDLE: begin
					if (go) begin
						st_q <= vfic_pkg::VFIC_WAIT;
						we_q <= w_q[`VFIC_GO_WRITE_BIT];
					end
				end
				vfic_pkg::VFIC_WAIT: begin
					if (link.ack) begin
						st_q <= vfic_pkg::VFIC_IDLE;
						if (!we_q) begin
							link_rdata_q <= link.rdata;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel; status shows busy and the two request lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= `VFIC_AXI_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rresp_q  <= `VFIC_AXI_OKAY;
				unique case (s_axi_araddr)
					{1'b0, `VFIC_CTL_ADDR}:   rdata_q <= cmd_addr_q;
					{1'b0, `VFIC_CTL_WDATA}:  rdata_q <= cmd_wdata_q;
					{1'b0, `VFIC_CTL_GO}:     rdata_q <= {31'h00000000, we_q};
					{1'b0, `VFIC_CTL_STATUS}: rdata_q <= {29'h00000000, link.fiq, link.irq,
						st_q == vfic_pkg::VFIC_WAIT};
					`VFIC_CTL_RDATA:          rdata_q <= link_rdata_q;
					default: begin
						rdata_q <= 32'h00000000;
						rresp_q <= `VFIC_AXI_SLVERR;
					end
				endcase
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Ready held low while frozen; otherwise a handshake would be lost
	assign s_axi_awready = ce && !have_aw_q && !bvalid_q;
	assign s_axi_wready  = ce && !have_w_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = ce && !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign link.req      = req_q;
	assign link.we       = we_q;
	assign link.addr     = cmd_addr_q;
	assign link.wdata    = cmd_wdata_q;
endmodule // vfic_ctl

// File: bench/vfic_link_props.sv
// Checker of the register link between the controller end and the device end
`include "vfic_consts.svh"
module vfic_link_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        req,
	input wire logic        we,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic        ack,
	input wire logic        irq,
	input wire logic        fiq
);
	logic [21:0] fen_q;
	logic [21:0] nen_q;
	logic [1:0]  soft_q;
	logic [15:0] base_q;
	logic [31:0] prio_q;
	logic        nest_q;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////////
	// Shadow masks from link writes; only sources 0..21 exist, so upper bits unchecked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fen_q <= '0;
			nen_q <= '0;
		end else if (req && we) begin
			case (addr)
				`VFIC_OFF_FAST_EN: begin
					fen_q <= fen_q | wdata[21:0];
					nen_q <= nen_q & ~wdata[21:0];
				end
				`VFIC_OFF_NORM_EN: begin
					nen_q <= nen_q | wdata[21:0];
					fen_q <= fen_q & ~wdata[21:0];
				end
				`VFIC_OFF_FAST_CLR: fen_q <= fen_q & ~wdata[21:0];
				`VFIC_OFF_NORM_CLR: nen_q <= nen_q & ~wdata[21:0];
				default: ;
			endcase
		end
	end
	// Shadow of the plain configuration words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_q <= '0;
			base_q <= '0;
			prio_q <= '0;
			nest_q <= 1'b0;
		end else if (req && we) begin
			if (addr == `VFIC_OFF_SOFT_CFG) soft_q <= wdata[2:1];
			if (addr == `VFIC_OFF_VEC_BASE) base_q <= wdata[15:0];
			if (addr == `VFIC_OFF_PRIO0) prio_q <= wdata;
			if (addr == `VFIC_OFF_NEST_CTRL) nest_q <= wdata[0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////////
	sequence s_read(logic [31:0] a);
		ack && !we && addr == a;
	endsequence
	sequence s_write(logic [31:0] a);
		req && we && addr == a;
	endsequence
	chk_ack_follows: assert property (req |=> ack)
		else $error("link request not answered next cycle");
	chk_ack_cause: assert property (ack |-> $past(req))
		else $error("link answer without request");
	chk_fast_mask: assert property (s_read(`VFIC_OFF_FAST_EN) |-> rdata[21:0] == fen_q)
		else $error("fast enable mask wrong");
	chk_norm_mask: assert property (s_read(`VFIC_OFF_NORM_EN) |-> rdata[21:0] == nen_q)
		else $error("normal enable mask wrong");
	chk_fast_status: assert property (s_read(`VFIC_OFF_FAST_STAT) |->
		(rdata[21:2] & ~fen_q[21:2]) == 20'h00000 && rdata[1] == soft_q[1])
		else $error("fast status not raw and mask");
	chk_clear_zero: assert property (s_read(`VFIC_OFF_FAST_CLR) |-> rdata == 32'h00000000)
		else $error("clear register readable");
	chk_base_word: assert property (s_read(`VFIC_OFF_VEC_BASE) |-> rdata == {16'h0000, base_q})
		else $error("vector base word wrong");
	chk_vector_fmt: assert property (s_read(`VFIC_OFF_VEC_PTR) |-> rdata[31:23] == 9'h000
		&& rdata[22:7] == base_q && rdata[6:2] <= 5'h15 && rdata[1:0] == 2'h0)
		else $error("vector pointer layout wrong");
	chk_prio_fields: assert property (s_read(`VFIC_OFF_PRIO0) |->
		rdata == (prio_q & `VFIC_PRIO0_MASK))
		else $error("priority word wrong");
	chk_soft_fast: assert property (s_write(`VFIC_OFF_SOFT_CFG) ##0 wdata[2] |-> ##2 fiq)
		else $error("soft fast request missing");
	chk_soft_norm: assert property (s_write(`VFIC_OFF_SOFT_CFG) ##0 (wdata[1] && !nest_q)
		|-> ##2 irq)
		else $error("soft normal request missing");
endmodule // vfic_link_props

// File: bench/testbench.sv
// Testbench joining controller and device ends, driven over AXI4-Lite
`include "vfic_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [31:0] wa; logic [31:0] wd; logic [31:0] ra; logic [31:0] ex;} vfic_row_t;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [1:0] bresp, rresp, rsp;
	logic [19:0] periph_src = 20'h00000;
	logic        ce = 1'b1;
	int err_total = 0, checks_done = 0, cycles = 0;
	vfic_row_t rows [10] = '{
		'{`VFIC_OFF_PRIO0, 32'hFFFFFFFF, `VFIC_OFF_PRIO0, 32'h77777770},
		'{`VFIC_OFF_VEC_BASE, 32'hFFFFFFFF, `VFIC_OFF_VEC_BASE, 32'h0000FFFF},
		'{32'h0, 32'h0, `VFIC_OFF_VEC_PTR, 32'h007FFF80},
		'{`VFIC_OFF_FAST_EN, 32'h00000F0C, `VFIC_OFF_FAST_EN, 32'h00000F0C},
		'{`VFIC_OFF_FAST_EN, 32'h00000030, `VFIC_OFF_FAST_EN, 32'h00000F3C},
		'{`VFIC_OFF_FAST_CLR, 32'h00000104, `VFIC_OFF_FAST_EN, 32'h00000E38}, // Nothing pends
		'{32'h0, 32'h0, `VFIC_OFF_FAST_CLR, 32'h00000000},
		'{`VFIC_OFF_NORM_EN, 32'h00000408, `VFIC_OFF_FAST_EN, 32'h00000A30},
		'{`VFIC_OFF_FAST_EN, 32'h00000400, `VFIC_OFF_NORM_EN, 32'h00000008},
		'{`VFIC_OFF_FAST_STAT, 32'hFFFFFFFF, `VFIC_OFF_FAST_STAT, 32'h00000000}};
	vfic_link_if link ();
	vfic_device i_vfic_device (.aclk(aclk), .aresetn(aresetn), .ce(ce), .periph_src(periph_src),
		.link(link));
	vfic_ctl i_vfic_ctl (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdat),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
	vfic_link_props i_vfic_link_props (.aclk(aclk), .aresetn(aresetn), .req(link.req),
		.we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
		.ack(link.ack), .irq(link.irq), .fiq(link.fiq));
	////////////////////////////////////////////////////////////////////////////////////
	// Free-running clock and hang guard
	always #4 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	// Ready is sampled at the falling edge; it cannot move before the next rising edge
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ha, hw, hb;
		hb = 1'b0;
		// Fresh edge, so the last release is never undone in the same step
		@(posedge aclk);
		awaddr <= a;
		wdat <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!hb) begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid && bready;
			r = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
		end
	endtask
	task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ha, hr;
		hr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!hr) begin
			@(negedge aclk);
			ha = arvalid && arready;
			hr = rvalid && rready;
			d = rdat;
			r = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
		end
	endtask
	// One device access: address, data, start, then poll busy and fetch read data
	task automatic dev_op(input logic [31:0] a, input logic [31:0] d, input logic wr,
		output logic [31:0] o);
		logic [1:0] r;
		logic [31:0] s;
		axi_wr(`VFIC_CTL_ADDR, a, r);
		axi_wr(`VFIC_CTL_WDATA, d, r);
		axi_wr(`VFIC_CTL_GO, {30'h0, wr, 1'b1}, r);
		s = 32'h1;
		while (s[0] === 1'b1) axi_rd(`VFIC_CTL_STATUS, s, r);
		axi_rd(`VFIC_CTL_RDATA, o, r);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] o;
		dev_op(a, d, 1'b1, o);
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] ex, input string msg);
		logic [31:0] o;
		dev_op(a, 32'h0, 1'b0, o);
		chk(o, ex, msg);
	endtask
	////////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(`VFIC_OFF_FAST_EN, 32'h0, "fast enable reset");
		rd_chk(`VFIC_OFF_VEC_BASE, 32'h0, "base reset");
		rd_chk(`VFIC_OFF_PRIO0, 32'h0, "priority reset");
		foreach (rows[i]) begin
			if (rows[i].wa != 32'h0) wr(rows[i].wa, rows[i].wd);
			rd_chk(rows[i].ra, rows[i].ex, "row");
		end
		// Sources 4 and 6 raised; only 4 is fast enabled
		periph_src <= 20'h00014;
		repeat (3) @(posedge aclk);
		rd_chk(`VFIC_OFF_FAST_STAT, 32'h00000010, "fast status");
		chk({31'h0, link.fiq}, 32'h1, "fiq set");
		rd_chk(`VFIC_OFF_FAST_RAW, 32'h00000051, "fast raw");
		wr(`VFIC_OFF_FAST_EN, 32'h00000001);
		rd_chk(`VFIC_OFF_FAST_STAT, 32'h00000011, "or source");
		periph_src <= 20'h00010;
		repeat (3) @(posedge aclk);
		chk({31'h0, link.fiq}, 32'h0, "masked fiq");
		// Clock enable low freezes the sampled sources and the request lines
		ce <= 1'b0;
		periph_src <= 20'h00004;
		repeat (3) @(posedge aclk);
		chk({31'h0, link.fiq}, 32'h0, "frozen fiq");
		ce <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({31'h0, link.fiq}, 32'h1, "thawed fiq");
		periph_src <= 20'h00010;
		// Programmed requests pass both masks
		wr(`VFIC_OFF_SOFT_CFG, 32'h00000004);
		rd_chk(`VFIC_OFF_FAST_STAT, 32'h00000003, "soft fast");
		rd_chk(`VFIC_OFF_FAST_RAW, 32'h00000043, "soft raw");
		wr(`VFIC_OFF_SOFT_CFG, 32'h00000002);
		rd_chk(`VFIC_OFF_FAST_STAT, 32'h0, "soft fast off");
		rd_chk(`VFIC_OFF_NORM_STAT, 32'h00000002, "soft normal");
		chk({31'h0, link.irq}, 32'h1, "irq set");
		wr(`VFIC_OFF_NEST_CTRL, 32'h00000001);
		rd_chk(`VFIC_OFF_VEC_PTR, 32'h007FFF84, "vector soft");
		// Sources 1..3 active normally, all at the lowest priority
		wr(`VFIC_OFF_NORM_EN, 32'h00000004);
		periph_src <= 20'h00013;
		repeat (3) @(posedge aclk);
		rd_chk(`VFIC_OFF_VEC_PTR, 32'h007FFF84, "tie lowest");
		wr(`VFIC_OFF_PRIO0, 32'h77772770);
		rd_chk(`VFIC_OFF_VEC_PTR, 32'h007FFF8C, "timer one wins");
		wr(`VFIC_OFF_PRIO0, 32'h77772270);
		rd_chk(`VFIC_OFF_VEC_PTR, 32'h007FFF88, "tie of two");
		// Fast outranks normal once vectoring is on
		wr(`VFIC_OFF_NEST_CTRL, 32'h00000001);
		wr(`VFIC_OFF_SOFT_CFG, 32'h00000006);
		chk({31'h0, link.irq, link.fiq}, 32'h1, "fast over normal");
		rd_chk(`VFIC_OFF_NEST_CTRL, 32'h00000001, "nesting bits");
		wr(`VFIC_OFF_NEST_CTRL, 32'h00000000);
		chk({31'h0, link.irq}, 32'h1, "irq back");
		rd_chk(32'hFFFF0040, 32'h0, "unmapped link read");
		axi_rd(5'h14, q, rsp);
		chk({30'h0, rsp}, {30'h0, `VFIC_AXI_SLVERR}, "axi read error");
		axi_wr(5'h14, 32'h1, rsp);
		chk({30'h0, rsp}, {30'h0, `VFIC_AXI_SLVERR}, "axi write error");
		// Second reset in mid-run clears the masks and soft requests
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(`VFIC_OFF_FAST_EN, 32'h0, "mask after reset");
		chk({30'h0, link.irq, link.fiq}, 32'h0, "lines after reset");
		test_done();
	end
endmodule // testbench
